// ---- hdl/icache_touch_debug.sv ----
`timescale 1ns/1ps
module icache_touch_debug #(
    parameter int CACHE_KB = icache_pkg::DEF_CACHE_KB
) (
    // Clock and reset
    input  logic                          clk,
    input  logic                          rst_b,
    // Configuration bits and processor state
    input  logic                          guaranteed_touch_enable,
    input  logic                          force_cacheop_miss,
    input  logic                          debug_read_parity_enable,
    input  logic                          privileged,
    // Cache-touch hint request
    input  logic                          touch_valid,
    input  icache_pkg::touch_s            touch,
    output logic                          touch_busy,
    output logic                          touch_installed,
    output logic                          touch_abandoned,
    // Demand fetch side
    input  logic                          demand_miss,
    input  logic                          other_req_pending,
    // Touch line fill on the system bus
    output logic                          bus_req,
    output logic [icache_pkg::WORD_W-1:0] bus_addr,
    input  logic                          bus_ack,
    input  logic                          bus_beat_valid,
    input  logic [icache_pkg::WORD_W-1:0] bus_beat_data,
    // Debug read
    input  logic                          debug_read_valid,
    input  logic [icache_pkg::WORD_W-1:0] debug_read_ea,
    output logic                          debug_done,
    output logic                          debug_priv_fault,
    output logic [icache_pkg::WORD_W-1:0] icache_debug_word,
    output logic [icache_pkg::WORD_W-1:0] icache_debug_tag_high,
    output logic [icache_pkg::WORD_W-1:0] icache_debug_tag_low
);

    localparam int WAY_HI = icache_pkg::MSB - icache_pkg::way_first(CACHE_KB);
    localparam int WAY_LO = icache_pkg::MSB - icache_pkg::way_last(CACHE_KB);
    localparam int SET_HI = icache_pkg::MSB - icache_pkg::set_first(CACHE_KB);
    localparam int WAY_W  = WAY_HI - WAY_LO + 1;
    localparam int SET_W  = SET_HI - icache_pkg::SET_LO + 1;
    localparam int IDX_W  = WAY_W + SET_W;
    localparam int LINES  = 1 << IDX_W;

    if (CACHE_KB != icache_pkg::KB_SMALL && CACHE_KB != icache_pkg::KB_MID &&
        CACHE_KB != icache_pkg::KB_LARGE)
    begin : g_bad_size
        $error("CACHE_KB must be 8, 16 or 32");
    end

    typedef enum {
        T_IDLE,
        T_REQ,
        T_FILL
    } touch_state_e;

    // Touch fill state.
    touch_state_e                                           state_reg;
    touch_state_e                                           state_next;
    icache_pkg::touch_s                                     tch_reg;
    icache_pkg::touch_s                                     tch_next;
    logic                                                   guar_reg;
    logic                                                   guar_next;
    logic [icache_pkg::BEAT_W-1:0]                          beat_reg;
    logic [icache_pkg::BEAT_W-1:0]                          beat_next;
    logic [icache_pkg::WORDS-1:0][icache_pkg::WORD_W-1:0]   buf_reg;
    logic [icache_pkg::WORDS-1:0][icache_pkg::WORD_W-1:0]   buf_next;
    logic [WAY_W-1:0]                                       victim_reg;
    logic [WAY_W-1:0]                                       victim_next;
    logic                                                   busy_reg;
    logic                                                   busy_next;
    logic                                                   installed_reg;
    logic                                                   installed_next;
    logic                                                   abandoned_reg;
    logic                                                   abandoned_next;
    logic                                                   bus_req_reg;
    logic                                                   bus_req_next;
    logic [icache_pkg::WORD_W-1:0]                          bus_addr_reg;
    logic [icache_pkg::WORD_W-1:0]                          bus_addr_next;

    // Debug read state.
    logic                                                   done_reg;
    logic                                                   done_next;
    logic                                                   fault_reg;
    logic                                                   fault_next;
    logic [icache_pkg::WORD_W-1:0]                          word_reg;
    logic [icache_pkg::WORD_W-1:0]                          word_next;
    logic [icache_pkg::WORD_W-1:0]                          tag_high_reg;
    logic [icache_pkg::WORD_W-1:0]                          tag_high_next;
    logic [icache_pkg::WORD_W-1:0]                          tag_low_reg;
    logic [icache_pkg::WORD_W-1:0]                          tag_low_next;

    // Line store ports.
    logic                                                   wr_en;
    logic [IDX_W-1:0]                                       wr_idx;
    icache_pkg::line_s                                      wr_line;
    logic [IDX_W-1:0]                                       rd_idx;
    icache_pkg::line_s                                      rd_line;
    logic [icache_pkg::BEAT_W-1:0]                          word_sel;
    logic [icache_pkg::TAG_EA_W-1:0]                        fill_tag;

    icache_line_store #(
        .LINES   (LINES),
        .IDX_W   (IDX_W)
    ) u_store (
        .clk     (clk),
        .rst_b   (rst_b),
        .wr_en   (wr_en),
        .wr_idx  (wr_idx),
        .wr_line (wr_line),
        .rd_idx  (rd_idx),
        .rd_line (rd_line)
    );

    // A touch fill lands in the set its address names, in a round-robin way.
    // A forced miss therefore lands in the round-robin way, even when that way holds the existing copy.
    assign wr_idx   = {victim_reg, tch_reg.ea[SET_HI:icache_pkg::SET_LO]};
    assign fill_tag = tch_reg.ea[icache_pkg::MSB:icache_pkg::TAG_EA_LO];

    // The line is built from the staged beats plus the final beat, so the
    // store sees only complete lines and never a half-filled valid one.
    always_comb
    begin
        wr_line           = '0;
        wr_line.data      = buf_reg;
        wr_line.data[icache_pkg::WORDS-1] = bus_beat_data;
        wr_line.valid     = 1'b1;
        wr_line.tag_ea    = fill_tag;
        wr_line.ts        = tch_reg.ts;
        wr_line.td        = tch_reg.td;
        wr_line.space_id_tag       = tch_reg.space_id_tag;
        wr_line.tag_par[0] = ^(fill_tag & icache_pkg::TAG_PAR_EVEN);
        wr_line.tag_par[1] = ^(fill_tag & ~icache_pkg::TAG_PAR_EVEN);
        for (int i = 0; i < icache_pkg::WORDS; i++)
        begin
            wr_line.word_par[i] = ^wr_line.data[i];
        end
    end

    always_comb
    begin
        state_next     = state_reg;
        tch_next       = tch_reg;
        guar_next      = guar_reg;
        beat_next      = beat_reg;
        buf_next       = buf_reg;
        victim_next    = victim_reg;
        bus_addr_next  = bus_addr_reg;
        installed_next = 1'b0;
        abandoned_next = 1'b0;
        wr_en          = 1'b0;
        case (state_reg)
            T_IDLE:
            begin
                // Uncacheable or untranslated touches are dropped without a fill.
                if (touch_valid && touch.xlate_ok && !touch.inhibited &&
                    (!touch.hit || force_cacheop_miss))
                begin
                    state_next    = T_REQ;
                    tch_next      = touch;
                    guar_next     = guaranteed_touch_enable;
                    beat_next     = '0;
                    bus_addr_next = {touch.ea[icache_pkg::MSB:icache_pkg::LINE_OFS_W], icache_pkg::LINE_OFS_ZERO};
                end
            end
            T_REQ:
            begin
                // An acknowledge in the same cycle as a demand miss keeps the fill.
                if (bus_req_reg && bus_ack)
                begin
                    state_next = T_FILL;
                end
                else if (demand_miss && !guar_reg)
                begin
                    state_next     = T_IDLE;
                    abandoned_next = 1'b1;
                end
            end
            T_FILL:
            begin
                // Once acknowledged the fill always completes.
                if (bus_beat_valid)
                begin
                    buf_next[beat_reg] = bus_beat_data;
                    beat_next          = beat_reg + 1'b1;
                    if (beat_reg == icache_pkg::LAST_BEAT)
                    begin
                        wr_en          = 1'b1;
                        installed_next = 1'b1;
                        victim_next    = victim_reg + 1'b1;
                        state_next     = T_IDLE;
                    end
                end
            end
            default:
            begin
                state_next = T_IDLE;
            end
        endcase
        busy_next    = (state_next != T_IDLE);
        // Any other request from the core holds the touch request off the bus.
        bus_req_next = (state_next == T_REQ) && !other_req_pending;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg     <= T_IDLE;
            tch_reg       <= '0;
            guar_reg      <= 1'b0;
            beat_reg      <= '0;
            buf_reg       <= '0;
            victim_reg    <= '0;
            busy_reg      <= 1'b0;
            installed_reg <= 1'b0;
            abandoned_reg <= 1'b0;
            bus_req_reg   <= 1'b0;
            bus_addr_reg  <= '0;
        end
        else
        begin
            state_reg     <= state_next;
            tch_reg       <= tch_next;
            guar_reg      <= guar_next;
            beat_reg      <= beat_next;
            buf_reg       <= buf_next;
            victim_reg    <= victim_next;
            busy_reg      <= busy_next;
            installed_reg <= installed_next;
            abandoned_reg <= abandoned_next;
            bus_req_reg   <= bus_req_next;
            bus_addr_reg  <= bus_addr_next;
        end
    end

    // The two lowest address bits are never looked at.
    assign rd_idx   = {debug_read_ea[WAY_HI:WAY_LO], debug_read_ea[SET_HI:icache_pkg::SET_LO]};
    assign word_sel = debug_read_ea[icache_pkg::WORD_SEL_HI:icache_pkg::WORD_SEL_LO];

    // Debug reads only copy stored bits; no parity check sits on this path.
    always_comb
    begin
        word_next     = word_reg;
        tag_high_next = tag_high_reg;
        tag_low_next  = tag_low_reg;
        done_next     = 1'b0;
        fault_next    = debug_read_valid && !privileged;
        if (debug_read_valid && privileged)
        begin
            done_next     = 1'b1;
            word_next     = rd_line.data[word_sel];
            tag_high_next = '0;
            tag_high_next[icache_pkg::MSB:icache_pkg::TAG_EA_LO] = rd_line.tag_ea;
            tag_high_next[icache_pkg::TAGH_VALID] = rd_line.valid;
            if (debug_read_parity_enable)
            begin
                tag_high_next[icache_pkg::TAGH_TAG_PARITY_BITS_LO+:icache_pkg::TAG_PARITY_BITS_W] = rd_line.tag_par;
                tag_high_next[icache_pkg::TAGH_DPAR] = rd_line.word_par[word_sel];
            end
            tag_low_next = '0;
            tag_low_next[icache_pkg::TAGL_TS] = rd_line.ts;
            tag_low_next[icache_pkg::TAGL_TD] = rd_line.td;
            tag_low_next[icache_pkg::TAGL_TID_LO+:icache_pkg::TID_W] = rd_line.space_id_tag;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            done_reg     <= 1'b0;
            fault_reg    <= 1'b0;
            word_reg     <= '0;
            tag_high_reg <= '0;
            tag_low_reg  <= '0;
        end
        else
        begin
            done_reg     <= done_next;
            fault_reg    <= fault_next;
            word_reg     <= word_next;
            tag_high_reg <= tag_high_next;
            tag_low_reg  <= tag_low_next;
        end
    end

    assign touch_busy            = busy_reg;
    assign touch_installed       = installed_reg;
    assign touch_abandoned       = abandoned_reg;
    assign bus_req               = bus_req_reg;
    assign bus_addr              = bus_addr_reg;
    assign debug_done            = done_reg;
    assign debug_priv_fault      = fault_reg;
    assign icache_debug_word     = word_reg;
    assign icache_debug_tag_high = tag_high_reg;
    assign icache_debug_tag_low  = tag_low_reg;

endmodule

// ---- hdl/icache_pkg.sv ----
package icache_pkg;

    // Bit n in big-endian numbering sits at vector position MSB - n.
    localparam int MSB        = 31;
    localparam int WORD_W     = 32;
    localparam int WORDS      = 8;
    localparam int BEAT_W     = 3;
    localparam int TAG_EA_W   = 24;
    localparam int TID_W      = 8;
    localparam int TAG_PARITY_BITS_W     = 2;
    localparam int LINE_OFS_W = 5;

    localparam int KB_SMALL     = 8;
    localparam int KB_MID       = 16;
    localparam int KB_LARGE     = 32;
    localparam int DEF_CACHE_KB = KB_LARGE;

    localparam int WAY_FIRST_SMALL = 19;
    localparam int WAY_FIRST_MID   = 18;
    localparam int WAY_FIRST_LARGE = 17;
    localparam int WAY_LAST_NARROW = 22;
    localparam int WAY_LAST_WIDE   = 23;
    localparam int SET_FIRST_WIDE  = 23;
    localparam int SET_FIRST_NARROW = 24;
    localparam int SET_LAST        = 26;

    localparam int WORD_SEL_HI  = MSB - 27;
    localparam int WORD_SEL_LO  = MSB - 29;
    localparam int SET_LO       = MSB - SET_LAST;
    localparam int TAG_EA_LO    = MSB - 23;
    localparam int TAGH_VALID   = MSB - 24;
    localparam int TAGH_TAG_PARITY_BITS_LO = MSB - 26;
    localparam int TAGH_DPAR    = MSB - 27;
    localparam int TAGL_TS      = MSB - 22;
    localparam int TAGL_TD      = MSB - 23;
    localparam int TAGL_TID_LO  = MSB - 31;

    localparam logic [BEAT_W-1:0]     LAST_BEAT    = 3'h7;
    localparam logic [TAG_EA_W-1:0]   TAG_PAR_EVEN = 24'h55_5555;
    localparam logic [LINE_OFS_W-1:0] LINE_OFS_ZERO = 5'h00;

    function automatic int way_first(input int kb);
        return (kb == KB_SMALL) ? WAY_FIRST_SMALL : (kb == KB_MID) ? WAY_FIRST_MID : WAY_FIRST_LARGE;
    endfunction

    function automatic int way_last(input int kb);
        return (kb == KB_LARGE) ? WAY_LAST_NARROW : WAY_LAST_WIDE;
    endfunction

    function automatic int set_first(input int kb);
        return (kb == KB_LARGE) ? SET_FIRST_WIDE : SET_FIRST_NARROW;
    endfunction

    typedef struct packed {
        logic [TAG_EA_W-1:0]          tag_ea;
        logic                         valid;
        logic [TAG_PARITY_BITS_W-1:0]            tag_par;
        logic                         ts;
        logic                         td;
        logic [TID_W-1:0]             space_id_tag;
        logic [WORDS-1:0]             word_par;
        logic [WORDS-1:0][WORD_W-1:0] data;
    } line_s;

    typedef struct packed {
        logic [WORD_W-1:0] ea;
        logic              hit;
        logic              xlate_ok;
        logic              inhibited;
        logic              ts;
        logic              td;
        logic [TID_W-1:0]  space_id_tag;
    } touch_s;

endpackage

// ---- hdl/icache_line_store.sv ----
`timescale 1ns/1ps
module icache_line_store #(
    parameter int LINES = 1024,
    parameter int IDX_W = 10
) (
    // Clock and reset
    input  logic              clk,
    input  logic              rst_b,
    // Write port
    input  logic              wr_en,
    input  logic [IDX_W-1:0]  wr_idx,
    input  icache_pkg::line_s wr_line,
    // Read port, combinational
    input  logic [IDX_W-1:0]  rd_idx,
    output icache_pkg::line_s rd_line
);

    icache_pkg::line_s mem_reg  [LINES];
    icache_pkg::line_s mem_next [LINES];

    if (LINES != (1 << IDX_W))
    begin : g_bad_depth
        $error("LINES must equal 2**IDX_W");
    end

    always_comb
    begin
        mem_next = mem_reg;
        if (wr_en)
        begin
            mem_next[wr_idx] = wr_line;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < LINES; i++)
            begin
                mem_reg[i] <= '0;
            end
        end
        else
        begin
            mem_reg <= mem_next;
        end
    end

    assign rd_line = mem_reg[rd_idx];

endmodule

// ---- verif/icache_touch_debug_asserts.sv ----
`timescale 1ns/1ps
module icache_touch_debug_asserts (
    // Clock and reset
    input logic                          clk,
    input logic                          rst_b,
    // Configuration and state
    input logic                          guaranteed_touch_enable,
    input logic                          force_cacheop_miss,
    input logic                          debug_read_parity_enable,
    input logic                          privileged,
    // Touch and fill bus
    input logic                          touch_valid,
    input icache_pkg::touch_s            touch,
    input logic                          touch_busy,
    input logic                          touch_installed,
    input logic                          touch_abandoned,
    input logic                          demand_miss,
    input logic                          other_req_pending,
    input logic                          bus_req,
    input logic [icache_pkg::WORD_W-1:0] bus_addr,
    input logic                          bus_ack,
    input logic                          bus_beat_valid,
    input logic [icache_pkg::WORD_W-1:0] bus_beat_data,
    // Debug read
    input logic                          debug_read_valid,
    input logic [icache_pkg::WORD_W-1:0] debug_read_ea,
    input logic                          debug_done,
    input logic                          debug_priv_fault,
    input logic [icache_pkg::WORD_W-1:0] icache_debug_word,
    input logic [icache_pkg::WORD_W-1:0] icache_debug_tag_high,
    input logic [icache_pkg::WORD_W-1:0] icache_debug_tag_low
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic take;
    assign take = touch_valid && !touch_busy && touch.xlate_ok && !touch.inhibited &&
                  (!touch.hit || force_cacheop_miss);

    prio_lowest_a: assert property (other_req_pending && $past(other_req_pending) |-> !bus_req)
        else $error("touch fill requested while another request waits");
    drop_on_miss_a: assert property (bus_req && !bus_ack && demand_miss && !guaranteed_touch_enable |=>
        touch_abandoned && !bus_req && !touch_busy) else $error("unacknowledged touch fill not dropped");
    ack_wins_a: assert property (bus_req && bus_ack |=> !bus_req && !touch_abandoned)
        else $error("acknowledged touch fill withdrawn or dropped");
    keep_guaranteed_a: assert property (guaranteed_touch_enable && touch_busy |=> !touch_abandoned)
        else $error("guaranteed touch fill dropped");
    touch_accept_a: assert property (take |=> touch_busy)
        else $error("eligible touch not started");
    touch_refuse_a: assert property (touch_valid && !touch_busy && !take |=> !touch_busy)
        else $error("ineligible touch started a fill");
    debug_answer_a: assert property (debug_read_valid && privileged |=> debug_done && !debug_priv_fault)
        else $error("privileged debug read not answered");
    debug_guard_a: assert property (debug_read_valid && !privileged |=> debug_priv_fault && !debug_done &&
        $stable(icache_debug_word) && $stable(icache_debug_tag_high) && $stable(icache_debug_tag_low))
        else $error("unprivileged debug read changed results");
    reserved_zero_a: assert property (debug_done |-> icache_debug_tag_high[3:0] == 4'h0 &&
        icache_debug_tag_low[31:10] == 22'h00_0000) else $error("reserved debug tag bits not zero");
    parity_off_a: assert property (debug_read_valid && privileged && !debug_read_parity_enable |=>
        icache_debug_tag_high[6:4] == 3'h0) else $error("parity fields loaded while disabled");

    cover property (touch_abandoned);
    cover property (touch_installed && force_cacheop_miss);
    cover property (debug_priv_fault);
    cover property (touch_busy && other_req_pending);
endmodule

// ---- verif/line_fill_mem.sv ----
`timescale 1ns/1ps
module line_fill_mem (
    // Clock and reset
    input  logic        clk,
    input  logic        rst_b,
    // Cycles of request seen before the acknowledge
    input  logic [3:0]  ack_delay,
    // Fill bus
    input  logic        bus_req,
    input  logic [31:0] bus_addr,
    output logic        bus_ack,
    output logic        bus_beat_valid,
    output logic [31:0] bus_beat_data
);
    logic [3:0]  wait_reg;
    logic [2:0]  beat_reg;
    logic        active_reg;
    logic [31:0] base_reg;

    // Outside beats the data lines toggle, so a stale word never passes for a fresh one.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {bus_ack, bus_beat_valid, active_reg} <= 3'h0;
            {wait_reg, beat_reg} <= 7'h00;
            {bus_beat_data, base_reg} <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            bus_ack <= 1'b0;
            bus_beat_valid <= 1'b0;
            bus_beat_data <= ~bus_beat_data;
            if (active_reg)
            begin
                bus_beat_valid <= 1'b1;
                bus_beat_data <= {base_reg[31:5], beat_reg, 2'b00};
                beat_reg <= beat_reg + 3'h1;
                active_reg <= (beat_reg != 3'h7);
            end
            else if (bus_req && !bus_ack && wait_reg >= ack_delay)
            begin
                bus_ack <= 1'b1;
                active_reg <= 1'b1;
                base_reg <= bus_addr;
                beat_reg <= 3'h0;
                wait_reg <= 4'h0;
            end
            else
                wait_reg <= bus_req ? wait_reg + 4'h1 : 4'h0;
        end
    end
endmodule

// ---- verif/test_icache_touch_debug.sv ----
`timescale 1ns/1ps
module test_icache_touch_debug;
    typedef struct packed {logic [31:0] ea; logic [7:0] space_id_tag; logic [2:0] word; logic pe;} row_s;
    logic clk, rst_b, guaranteed_touch_enable, force_cacheop_miss, debug_read_parity_enable, privileged;
    logic touch_valid, touch_busy, touch_installed, touch_abandoned, demand_miss, other_req_pending;
    logic bus_req, bus_ack, bus_beat_valid, debug_read_valid, debug_done, debug_priv_fault;
    logic [31:0] bus_addr, bus_beat_data, debug_read_ea, icache_debug_word, icache_debug_tag_high, icache_debug_tag_low;
    logic [31:0] snap;
    logic [3:0]  ack_delay;
    logic [1:0]  r;
    icache_pkg::touch_s touch;
    int fails, checks, cycles, way_ctr;
    localparam logic [31:0] AB = 32'h0F0F_01E0;
    row_s rows [4] = '{'{32'h0000_0000, 8'h00, 3'h0, 1'b1}, '{32'h1234_5620, 8'hA5, 3'h7, 1'b1},
                       '{32'hFFFF_FF40, 8'hFF, 3'h3, 1'b0}, '{32'h8765_43E0, 8'h5A, 3'h5, 1'b1}};

    icache_touch_debug #(.CACHE_KB(32)) dut (.*);
    line_fill_mem mem (.clk(clk), .rst_b(rst_b), .ack_delay(ack_delay), .bus_req(bus_req), .bus_addr(bus_addr),
        .bus_ack(bus_ack), .bus_beat_valid(bus_beat_valid), .bus_beat_data(bus_beat_data));

    function automatic logic [31:0] exp_high(input logic [31:0] ea, input logic [2:0] w, input logic pe);
        logic [23:0] tag;
        tag = ea[31:8];
        if (!pe)
            return {tag, 1'b1, 7'h00};
        return {tag, 1'b1, ^(tag & ~icache_pkg::TAG_PAR_EVEN), ^(tag & icache_pkg::TAG_PAR_EVEN), ^{ea[31:5], w}, 4'h0};
    endfunction

    function automatic logic [31:0] dbg_ea(input int way, input logic [3:0] set, input logic [2:0] w);
        return {17'h0_0000, 6'(way), set, w, 2'b00};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (fails == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic touch_go(input logic [31:0] ea, input logic hit, input logic [1:0] bad, input logic dm,
                            input logic [7:0] space_id_tag);
        @(posedge clk);
        touch_valid <= 1'b1;
        touch <= '{ea: ea, hit: hit, xlate_ok: !bad[1], inhibited: bad[0], ts: space_id_tag[0], td: space_id_tag[1], space_id_tag: space_id_tag};
        @(posedge clk);
        touch_valid <= 1'b0;
        demand_miss <= dm;
        @(posedge clk);
        demand_miss <= 1'b0;
    endtask

    // A bounded wait: a fill that never ends returns zero instead of hanging.
    task automatic wait_end();
        r = 2'b00;
        repeat (40)
        begin
            @(negedge clk);
            if (touch_installed === 1'b1 || touch_abandoned === 1'b1)
            begin
                r = {touch_abandoned, touch_installed};
                break;
            end
        end
    endtask

    task automatic dbg(input logic [31:0] ea, input logic priv, input logic pe);
        @(posedge clk);
        debug_read_valid <= 1'b1;
        debug_read_ea <= ea;
        privileged <= priv;
        debug_read_parity_enable <= pe;
        @(posedge clk);
        debug_read_valid <= 1'b0;
        @(negedge clk);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            final_report();
        end
    end

    initial
    begin
        {rst_b, guaranteed_touch_enable, force_cacheop_miss, debug_read_parity_enable, privileged} = 5'h00;
        {touch_valid, demand_miss, other_req_pending, debug_read_valid} = 4'h0;
        touch = '0;
        debug_read_ea = 32'h0000_0000;
        ack_delay = 4'h0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk({bus_req, touch_busy, touch_installed, touch_abandoned, debug_done, debug_priv_fault}, 32'h0000_0000);
        chk(icache_debug_tag_high | icache_debug_word | icache_debug_tag_low, 32'h0000_0000);
        @(posedge clk) rst_b <= 1'b1;
        foreach (rows[i])
        begin
            touch_go(rows[i].ea, 1'b0, 2'b00, 1'b0, rows[i].space_id_tag);
            wait_end();
            chk(32'(r), 32'h0000_0001);
            way_ctr++;
            dbg(dbg_ea(way_ctr - 1, rows[i].ea[8:5], rows[i].word), 1'b1, rows[i].pe);
            chk(32'(debug_done), 32'h0000_0001);
            chk(icache_debug_word, {rows[i].ea[31:5], rows[i].word, 2'b00});
            chk(icache_debug_tag_high, exp_high(rows[i].ea, rows[i].word, rows[i].pe));
            chk(icache_debug_tag_low, {22'h00_0000, rows[i].space_id_tag[0], rows[i].space_id_tag[1], rows[i].space_id_tag});
        end
        touch_go(rows[1].ea, 1'b1, 2'b00, 1'b0, 8'h01);
        chk(32'(touch_busy), 32'h0000_0000);
        touch_go(AB, 1'b0, 2'b01, 1'b0, 8'h01);
        chk(32'(touch_busy), 32'h0000_0000);
        touch_go(AB, 1'b0, 2'b10, 1'b0, 8'h01);
        chk(32'(touch_busy), 32'h0000_0000);
        force_cacheop_miss <= 1'b1;
        touch_go(rows[1].ea, 1'b1, 2'b00, 1'b0, rows[1].space_id_tag);
        wait_end();
        chk(32'(r), 32'h0000_0001);
        way_ctr++;
        force_cacheop_miss <= 1'b0;
        dbg(dbg_ea(way_ctr - 1, rows[1].ea[8:5], 3'h2), 1'b1, 1'b1);
        chk(icache_debug_tag_high, exp_high(rows[1].ea, 3'h2, 1'b1));
        ack_delay <= 4'h3;
        touch_go(AB, 1'b0, 2'b00, 1'b1, 8'h11);
        wait_end();
        chk(32'(r), 32'h0000_0002);
        chk(32'({bus_req, touch_busy}), 32'h0000_0000);
        dbg(dbg_ea(way_ctr, 4'hF, 3'h0), 1'b1, 1'b1);
        chk(32'(icache_debug_tag_high[7]), 32'h0000_0000);
        guaranteed_touch_enable <= 1'b1;
        ack_delay <= 4'h6;
        touch_go(AB, 1'b0, 2'b00, 1'b1, 8'h11);
        wait_end();
        chk(32'(r), 32'h0000_0001);
        way_ctr++;
        guaranteed_touch_enable <= 1'b0;
        ack_delay <= 4'h0;
        dbg(dbg_ea(way_ctr - 1, 4'hF, 3'h1), 1'b1, 1'b1);
        chk(icache_debug_tag_high, exp_high(AB, 3'h1, 1'b1));
        other_req_pending <= 1'b1;
        touch_go(rows[2].ea, 1'b0, 2'b00, 1'b0, 8'h22);
        repeat (4) @(negedge clk);
        chk(32'({bus_req, touch_busy}), 32'h0000_0001);
        other_req_pending <= 1'b0;
        wait_end();
        chk(32'(r), 32'h0000_0001);
        snap = icache_debug_word;
        dbg(dbg_ea(0, 4'h0, 3'h4), 1'b0, 1'b1);
        chk(32'({debug_priv_fault, debug_done}), 32'h0000_0002);
        chk(icache_debug_word, snap);
        final_report();
    end
endmodule

bind icache_touch_debug icache_touch_debug_asserts chk_i (.*);
